/* rtl/interrupt_vector_map.v */
`timescale 1ns/10ps
`default_nettype none
`include "interrupt_vector_map_regs.vh"

module interrupt_vector_map
#(
    parameter PINS = `IVM_PINS_LARGE
)
(
    // Clock and reset
    input  wire                    MCLK_IN,
    input  wire                    SYS_RST_IN,
    // Source events, one bit per vector
    input  wire [`IVM_NUM_VEC-1:0] EVENT_IN,
    input  wire [`IVM_TA_SPAN-1:0] TA_NORMAL_EV_IN,
    input  wire [`IVM_TA_SPAN-1:0] TA_SPLIT_EV_IN,
    input  wire                    TA_SPLIT_MODE_IN,
    // Enable write port
    input  wire                    EN_WE_IN,
    input  wire [`IVM_VEC_W-1:0]   EN_VEC_IN,
    input  wire                    EN_VAL_IN,
    // Flag clear port
    input  wire                    CLR_WE_IN,
    input  wire [`IVM_VEC_W-1:0]   CLR_VEC_IN,
    // Global enable
    input  wire                    GIE_IN,
    // State
    output reg  [`IVM_NUM_VEC-1:0] FLAG_OUT,
    output reg  [`IVM_NUM_VEC-1:0] ENABLE_OUT,
    output reg  [`IVM_NUM_VEC-1:0] PENDING_OUT,
    // Presented vector
    output reg                     IRQ_OUT,
    output reg                     NMI_OUT,
    output reg  [`IVM_VEC_W-1:0]   VEC_NUM_OUT,
    output reg  [`IVM_ADDR_W-1:0]  VEC_ADDR_OUT,
    output reg  [`IVM_VEC_W-1:0]   OWNER_OUT
);

    localparam NV = `IVM_NUM_VEC;
    localparam VW = `IVM_VEC_W;
    localparam AW = `IVM_ADDR_W;

    // ==========================================================
    // Functions
    function [NV-1:0] onehot;
        input [VW-1:0] v;
        begin
            onehot = {NV{1'b0}};
            if (v < NV)
                onehot[v] = 1'b1;
        end
    endfunction

    // Vector exists on this package; reset has no flag source
    function avail;
        input [VW-1:0] v;
        begin
            avail = 1'b1;
            if (v == `IVM_VEC_RESET)
                avail = 1'b0;
            if (v == `IVM_VEC_TB3 || v == `IVM_VEC_PORTB)
                avail = (PINS >= `IVM_PINS_LARGE);
            if (v == `IVM_VEC_TW1_CLIENT || v == `IVM_VEC_TW1_HOST)
                avail = (PINS > `IVM_PINS_SMALL);
        end
    endfunction

    // Lowest vector of the owning instance identifies it uniquely
    function [VW-1:0] owner;
        input [VW-1:0] v;
        begin
            owner = v;
            if (v == `IVM_VEC_PERIODIC)
                owner = `IVM_VEC_RTC_CNT;
            if (v >= `IVM_VEC_TA_FIRST && v <= `IVM_VEC_TA_LAST)
                owner = `IVM_VEC_TA_FIRST;
            if (v == `IVM_VEC_TD_TIMER_TRIGGER)
                owner = `IVM_VEC_TD_OVF;
            if (v == `IVM_VEC_TW0_HOST)
                owner = `IVM_VEC_TW0_CLIENT;
            if (v == `IVM_VEC_TW1_HOST)
                owner = `IVM_VEC_TW1_CLIENT;
            if (v >= `IVM_VEC_SER0 && v <= `IVM_VEC_SER0_LAST)
                owner = `IVM_VEC_SER0;
            if (v >= `IVM_VEC_SER1 && v <= `IVM_VEC_SER1_LAST)
                owner = `IVM_VEC_SER1;
            if (v >= `IVM_VEC_SER2 && v <= `IVM_VEC_SER2_LAST)
                owner = `IVM_VEC_SER2;
            if (v == `IVM_VEC_ADC_WIN)
                owner = `IVM_VEC_ADC_RES;
        end
    endfunction

    // ==========================================================
    // Event gathering
    reg  [`IVM_TA_SPAN-1:0] ta_ev;
    reg  [NV-1:0]           ev_vec;
    reg  [NV-1:0]           nmi_mask;
    integer                 i;

    always @*
    begin
        // Normal mode leaves the high-underflow slot unused
        if (TA_SPLIT_MODE_IN)
            ta_ev = TA_SPLIT_EV_IN;
        else
            ta_ev = TA_NORMAL_EV_IN & `IVM_TA_NORMAL_MASK;
        ev_vec = EVENT_IN;
        ev_vec[`IVM_VEC_TA_FIRST +: `IVM_TA_SPAN] = ta_ev;
        for (i = 0; i < NV; i = i + 1)
            ev_vec[i] = ev_vec[i] & avail(i[VW-1:0]);
        nmi_mask = onehot(`IVM_VEC_NMI);
    end

    // ==========================================================
    // Flags and enables
    reg  [NV-1:0] flag_reg;
    reg  [NV-1:0] flag_next;
    reg  [NV-1:0] en_reg;
    reg  [NV-1:0] en_next;
    reg  [NV-1:0] req_next;
    reg  [NV-1:0] clr_sel;
    reg  [NV-1:0] en_sel;

    always @*
    begin
        clr_sel = onehot(CLR_VEC_IN) & {NV{CLR_WE_IN}};
        en_sel  = onehot(EN_VEC_IN) & {NV{EN_WE_IN}};
        // Set beats clear so a coincident event is kept
        flag_next = (flag_reg & ~clr_sel) | ev_vec;
        en_next = (en_reg & ~en_sel) | (en_sel & {NV{EN_VAL_IN}});
        // Next-state terms so a clear drops the request at its own edge
        req_next = flag_next & (en_next | nmi_mask)
                 & ({NV{GIE_IN}} | nmi_mask);
    end

    // ==========================================================
    // Priority pick
    wire          pick_found;
    wire [VW-1:0] pick_idx;

    lowest_pick
    #(
        .N  (NV),
        .IW (VW)
    )
    u_pick
    (
        .req_in    (req_next),
        .found_out (pick_found),
        .idx_out   (pick_idx)
    );

    // ==========================================================
    // Registers
    always @(posedge MCLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            flag_reg     <= {NV{1'b0}};
            en_reg       <= {NV{1'b0}};
            FLAG_OUT     <= {NV{1'b0}};
            ENABLE_OUT   <= {NV{1'b0}};
            PENDING_OUT  <= {NV{1'b0}};
            IRQ_OUT      <= 1'b0;
            NMI_OUT      <= 1'b0;
            VEC_NUM_OUT  <= `IVM_VEC_RESET;
            VEC_ADDR_OUT <= {AW{1'b0}};
            OWNER_OUT    <= `IVM_VEC_RESET;
        end
        else
        begin
            flag_reg    <= flag_next;
            en_reg      <= en_next;
            FLAG_OUT    <= flag_next;
            ENABLE_OUT  <= en_next;
            PENDING_OUT <= req_next;
            IRQ_OUT     <= pick_found;
            NMI_OUT     <= req_next[`IVM_VEC_NMI];
            // Idle shows the reset vector
            VEC_NUM_OUT  <= pick_found ? pick_idx : `IVM_VEC_RESET;
            VEC_ADDR_OUT <= pick_found ? {pick_idx, 1'b0} : {AW{1'b0}};
            OWNER_OUT    <= pick_found ? owner(pick_idx) : `IVM_VEC_RESET;
        end
    end

endmodule // interrupt_vector_map

`default_nettype wire

/* inc/interrupt_vector_map_regs.vh */
// Behaviour
// - A source event sets its flag whether or not the source is enabled.
// - Writing a source's enable bit enables or disables that source alone.
// - A request is raised only while the source's enable and flag are both set; vector 1 needs only its flag.
// - No request other than vector 1's is raised unless the global enable is set as well.
// - A request stays active until its flag is cleared by the handler's strobe or (except vector 1) its enable is cleared or the global enable drops.
// - Each vector belongs to one instance; one instance may own several vectors.
// - Vector 0 (0x00) is reset; vector 1 (0x02) is the non-maskable scanner one.
// - Vector 2 (0x04) carries the voltage level monitor interrupt.
// - Real-time counter: 0x06 for overflow or compare, 0x08 for periodic tick.
// - Vector 5 (0x0A) carries the custom logic interrupt.
// - Timer A vectors 7 to 11 follow normal or split mode meanings.
// - Timer B instances use 0x18, 0x1A, 0x3C and 0x52 (largest package only).
// - Timer D overflow at 0x1C and trigger at 0x1E.
// - Two-wire instances: 0x20/0x22, and 0x54/0x56 absent on smallest package.
// - Serial peripheral interface instances at 0x24 and 0x48.
// - Serial ports have receive, buffer empty, transmit at 0x26, 0x3E, 0x4A.
// - Converter result ready at 0x30 and window compare at 0x32.
// - Comparators at 0x2E, 0x38, 0x50; zero-cross 0x34; touch 0x36.
// - Data-memory ready interrupt on vector 35 at 0x46.
// - Each vector's word address is twice its vector number.
`ifndef INTERRUPT_VECTOR_MAP_REGS_VH
`define INTERRUPT_VECTOR_MAP_REGS_VH

// ==========================================================
// Sizes
`define IVM_NUM_VEC         45
`define IVM_VEC_W           6
`define IVM_ADDR_W          7
`define IVM_PINS_SMALL      28
`define IVM_PINS_LARGE      48
`define IVM_TA_SPAN         5
`define IVM_TA_NORMAL_MASK  5'h1D

// ==========================================================
// Vector numbers
`define IVM_VEC_RESET       6'h00
`define IVM_VEC_NMI         6'h01
`define IVM_VEC_VLM         6'h02
`define IVM_VEC_RTC_CNT     6'h03
`define IVM_VEC_PERIODIC    6'h04
`define IVM_VEC_CUSTOM      6'h05
`define IVM_VEC_PORTA       6'h06
`define IVM_VEC_TA_FIRST    6'h07
`define IVM_VEC_TA_LAST     6'h0B
`define IVM_VEC_TB0         6'h0C
`define IVM_VEC_TB1         6'h0D
`define IVM_VEC_TD_OVF      6'h0E
`define IVM_VEC_TD_TIMER_TRIGGER     6'h0F
`define IVM_VEC_TW0_CLIENT  6'h10
`define IVM_VEC_TW0_HOST    6'h11
`define IVM_VEC_SPI0        6'h12
`define IVM_VEC_SER0        6'h13
`define IVM_VEC_SER0_LAST   6'h15
`define IVM_VEC_PORTD       6'h16
`define IVM_VEC_AC0         6'h17
`define IVM_VEC_ADC_RES     6'h18
`define IVM_VEC_ADC_WIN     6'h19
`define IVM_VEC_ZCD         6'h1A
`define IVM_VEC_TOUCH       6'h1B
`define IVM_VEC_AC1         6'h1C
`define IVM_VEC_PORTC       6'h1D
`define IVM_VEC_TB2         6'h1E
`define IVM_VEC_SER1        6'h1F
`define IVM_VEC_SER1_LAST   6'h21
`define IVM_VEC_PORTF       6'h22
`define IVM_VEC_NVM         6'h23
`define IVM_VEC_SPI1        6'h24
`define IVM_VEC_SER2        6'h25
`define IVM_VEC_SER2_LAST   6'h27
`define IVM_VEC_AC2         6'h28
`define IVM_VEC_TB3         6'h29
`define IVM_VEC_TW1_CLIENT  6'h2A
`define IVM_VEC_TW1_HOST    6'h2B
`define IVM_VEC_PORTB       6'h2C

`endif

/* rtl/lowest_pick.v */
`timescale 1ns/10ps
`default_nettype none

module lowest_pick
#(
    parameter N  = 45,
    parameter IW = 6
)
(
    // Request vector
    input  wire [N-1:0]  req_in,
    // Winner
    output reg           found_out,
    output reg  [IW-1:0] idx_out
);

    integer i;

    // ==========================================================
    // Scan from the top so the lowest set bit is written last
    always @*
    begin
        found_out = 1'b0;
        idx_out   = {IW{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1)
        begin
            if (req_in[i])
            begin
                found_out = 1'b1;
                idx_out   = i[IW-1:0];
            end
        end
    end

endmodule // lowest_pick

`default_nettype wire

/* bench/cpu_fetch_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Handler side: clears the presented flag
module cpu_fetch_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       irq,
    input  wire logic       on,
    input  wire logic       slow,
    input  wire logic [5:0] vec,
    output var  logic       clr_we,
    output var  logic [5:0] clr_vec
);
    int wait_n;
    initial
    begin
        clr_we = 1'b0;
        clr_vec = 6'h00;
        wait_n = 0;
    end
    // One idle cycle after each clear (five when slow), so a stale vector is never cleared twice
    always @(negedge clk)
        if (rst || !on || !irq || clr_we)
        begin
            if (clr_we)
                clr_vec <= ~clr_vec;
            clr_we <= 1'b0;
            wait_n <= slow ? 4 : 0;
        end
        else if (wait_n > 0)
            wait_n <= wait_n - 1;
        else
        begin
            clr_we <= 1'b1;
            clr_vec <= vec;
        end
endmodule // cpu_fetch_model
`default_nettype wire

/* bench/ivm_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checker
module ivm_chk (
    input wire logic        MCLK_IN,
    input wire logic        SYS_RST_IN,
    input wire logic [44:0] EVENT_IN,
    input wire logic        CLR_WE_IN,
    input wire logic [5:0]  CLR_VEC_IN,
    input wire logic        GIE_IN,
    input wire logic [44:0] FLAG_OUT,
    input wire logic [44:0] ENABLE_OUT,
    input wire logic [44:0] PENDING_OUT,
    input wire logic        IRQ_OUT,
    input wire logic        NMI_OUT,
    input wire logic [5:0]  VEC_NUM_OUT,
    input wire logic [6:0]  VEC_ADDR_OUT,
    input wire logic [5:0]  OWNER_OUT
);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    wire [44:0] lo_mask = (45'h1 << VEC_NUM_OUT) - 45'h1;
    sequence s_clr;
        CLR_WE_IN && CLR_VEC_IN > 11 && CLR_VEC_IN < 45 && !EVENT_IN[CLR_VEC_IN];
    endsequence
    property p_addr; VEC_ADDR_OUT == {VEC_NUM_OUT, 1'b0}; endproperty
    a_addr: assert property (p_addr) else $error("vector address off");
    property p_flag; EVENT_IN[2] |=> FLAG_OUT[2]; endproperty
    a_flag: assert property (p_flag) else $error("event lost");
    property p_gate;
        ((PENDING_OUT & ~FLAG_OUT) | (PENDING_OUT & ~ENABLE_OUT & ~45'h2)) == 45'h0;
    endproperty
    a_gate: assert property (p_gate) else $error("request without cause");
    property p_gie; |(PENDING_OUT & ~45'h2) |-> $past(GIE_IN); endproperty
    a_gie: assert property (p_gie) else $error("request with global off");
    property p_hold; !CLR_WE_IN |=> (FLAG_OUT & $past(FLAG_OUT)) == $past(FLAG_OUT); endproperty
    a_hold: assert property (p_hold) else $error("flag dropped uncleared");
    property p_drop;
        s_clr |=> !FLAG_OUT[$past(CLR_VEC_IN)] && !PENDING_OUT[$past(CLR_VEC_IN)];
    endproperty
    a_drop: assert property (p_drop) else $error("clear ignored");
    property p_low;
        IRQ_OUT == (|PENDING_OUT) &&
        (!IRQ_OUT || (PENDING_OUT[VEC_NUM_OUT] && (PENDING_OUT & lo_mask) == 45'h0));
    endproperty
    a_low: assert property (p_low) else $error("wrong vector presented");
    property p_nmi; EVENT_IN[1] |=> NMI_OUT && PENDING_OUT[1]; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi masked");
    property p_own; VEC_NUM_OUT inside {6'd20, 6'd21} |-> OWNER_OUT == 6'd19; endproperty
    a_own: assert property (p_own) else $error("owner off");
endmodule // ivm_chk
bind interrupt_vector_map ivm_chk CHK (.*);
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk, rst, we, val, gie, mode, on, slow, irq, nmi, cwe;
    logic [44:0] ev, flag, en, pend, m_flag, m_en, m_pend, f28;
    logic [4:0]  tn, ts;
    logic [5:0]  ev_vec, vnum, own, cvec;
    logic [6:0]  vadr;
    logic [31:0] r;
    int          n_fail, checks, seed, i;
    interrupt_vector_map #(.PINS(48)) DUT (.MCLK_IN(clk), .SYS_RST_IN(rst), .EVENT_IN(ev),
        .TA_NORMAL_EV_IN(tn), .TA_SPLIT_EV_IN(ts), .TA_SPLIT_MODE_IN(mode), .EN_WE_IN(we),
        .EN_VEC_IN(ev_vec), .EN_VAL_IN(val), .CLR_WE_IN(cwe), .CLR_VEC_IN(cvec),
        .GIE_IN(gie), .FLAG_OUT(flag), .ENABLE_OUT(en), .PENDING_OUT(pend), .IRQ_OUT(irq),
        .NMI_OUT(nmi), .VEC_NUM_OUT(vnum), .VEC_ADDR_OUT(vadr), .OWNER_OUT(own));
    // Smallest package copy: vectors 41 to 44 must never flag
    interrupt_vector_map #(.PINS(28)) DUT_SMALL (.MCLK_IN(clk), .SYS_RST_IN(rst),
        .EVENT_IN(ev), .TA_NORMAL_EV_IN(tn), .TA_SPLIT_EV_IN(ts), .TA_SPLIT_MODE_IN(mode),
        .EN_WE_IN(we), .EN_VEC_IN(ev_vec), .EN_VAL_IN(val), .CLR_WE_IN(cwe),
        .CLR_VEC_IN(cvec), .GIE_IN(gie), .FLAG_OUT(f28), .ENABLE_OUT(), .PENDING_OUT(),
        .IRQ_OUT(), .NMI_OUT(), .VEC_NUM_OUT(), .VEC_ADDR_OUT(), .OWNER_OUT());
    cpu_fetch_model CPU (.clk(clk), .rst(rst), .irq(irq), .on(on), .slow(slow),
        .vec(vnum), .clr_we(cwe), .clr_vec(cvec));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Owner is the lowest vector of the owning instance
    function automatic logic [5:0] owner(input logic [5:0] v);
        case (v)
            4: return 6'd3;
            8, 9, 10, 11: return 6'd7;
            15: return 6'd14;
            17: return 6'd16;
            20, 21: return 6'd19;
            25: return 6'd24;
            32, 33: return 6'd31;
            38, 39: return 6'd37;
            43: return 6'd42;
            default: return v;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [44:0] seen, input logic [44:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic do_reset(input int n);
        rst = 1'b1;
        m_flag = '0;
        m_en = '0;
        m_pend = '0;
        repeat (n) @(negedge clk);
        rst = 1'b0;
    endtask
    task automatic drive;
        r = $random(seed);
        ev = '0;
        if (r[1:0] == 2'b00)
            ev[r[31:26] % 45] = 1'b1;
        tn = r[4:0] & r[9:5] & r[14:10];
        ts = r[19:15] & r[24:20] & r[29:25];
        r = $random(seed);
        we = r[0];
        ev_vec = r[6:1];
        val = r[7] | r[8];
        gie = r[11:9] != 3'h0;
        mode = (r[15:12] == 4'h0) ? ~mode : mode;
        slow = r[16];
    endtask
    task automatic step;
        logic [44:0] s;
        logic [5:0]  lo;
        @(posedge clk);
        s = ev & ~45'h0f81;
        s[11:7] = mode ? ts : (tn & 5'h1d);
        m_flag = s | (m_flag & ~((cwe && cvec < 45) ? 45'h1 << cvec : 45'h0));
        if (we && ev_vec < 45)
            m_en[ev_vec] = val;
        m_pend = m_flag & (m_en | 45'h2) & (gie ? {45{1'b1}} : 45'h2);
        @(negedge clk);
        lo = 6'h00;
        for (int k = 44; k >= 0; k--)
            if (m_pend[k])
                lo = k[5:0];
        chk("flag", flag, m_flag);
        chk("enable", en, m_en);
        chk("pending", pend, m_pend);
        chk("irq", irq, |m_pend);
        chk("nmi", nmi, m_pend[1]);
        chk("vector", vnum, lo);
        chk("address", vadr, {lo, 1'b0});
        chk("owner", own, owner(lo));
        chk("flag28", f28, m_flag & ~45'h1E00_0000_0000);
    endtask
    initial
    begin
        #100000;
        n_fail++;
        end_sim;
    end
    initial
    begin
        seed = 32'h7462;
        n_fail = 0;
        checks = 0;
        {ev, tn, ts, we, ev_vec, val, gie, mode} = '0;
        on = 1'b1;
        slow = 1'b0;
        do_reset(10);
        for (i = 0; i < 1800; i++)
        begin
            // Stalled handler lets flags pile up
            on = (i < 1200 || i > 1400);
            if (i == 900)
                do_reset(3);
            drive;
            step;
        end
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
